// ---- design/rcw_defs.svh ----
// Register offsets, field positions, reset values and counts for the
// reset, clock and watchdog block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, data in lane 0.
`ifndef RCW_DEFS_SVH
`define RCW_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_TMR1_CTRL 8'hc0
`define OFS_TMR1_COUNT 8'hc4
`define OFS_TMR1_PRESC 8'hc8
`define OFS_AR_MODE 8'hcc
`define OFS_PORT_OPTION 8'hd0
`define OFS_WD_CTRL 8'hd8
`define OFS_CORE_STATUS 8'hdc

// ****************************************
// Reset values
// ****************************************
`define RST_TMR1_CTRL 8'h00
`define RST_TMR1_COUNT 8'hff
`define RST_TMR1_PRESC 8'h7f
`define RST_AR_MODE 8'h00
`define RST_PORT_OPTION 8'h00
`define RST_WD_CTRL 8'hfe
`define RESET_VECTOR 12'hffe

// ****************************************
// Watchdog register fields
// ****************************************
`define WD_ACT_BIT 0
`define WD_SOFT_RESET_BIT 1

// ****************************************
// Timing counts in sys_clk cycles; INSTR_MIN_CYCLES is in core ticks
// ****************************************
`define CORE_DIV 4'd13
`define CONV_WD_DIV 4'd12
`define STAB_CYCLES 12'd2048
`define INSTR_MIN_CYCLES 3'd2

`endif

// ---- design/rcw_pkg.sv ----
// Types shared by the reset, clock and watchdog block.
// Assumes nothing beyond a SystemVerilog compiler.
package rcw_pkg;

    typedef enum logic [1:0] {pm_run, pm_wait, pm_stop} power_mode_e;
    typedef enum logic [1:0] {rs_hold, rs_stab, rs_init, rs_normal} reset_state_e;
    typedef logic [6:0] wd_count_t;
    typedef logic [11:0] prog_addr_t;

endpackage : rcw_pkg

// ---- design/mcu_reset_clock_watchdog.sv ----
// Clock division, reset sequencing and digital watchdog of a small core.
// Assumes ext_reset_n is synchronous to sys_clk after the two-stage
// synchroniser, and reset_n stands for power-on detection.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`include "rcw_defs.svh"

module mcu_reset_clock_watchdog (
    // Clock and power-on reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // External reset pin and option bit
    input wire logic ext_reset_n,
    input wire logic watchdog_hw_select,
    // Core requests
    input wire logic stop_req,
    input wire logic wait_req,
    input wire logic wake_irq,
    input wire logic return_from_interrupt,
    input wire logic irq_pending,
    input wire logic instr_start,
    input wire logic [2:0] instr_cycles,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Clocks and reset to the core
    output logic core_tick,
    output logic conv_wd_tick,
    output logic core_reset,
    output logic io_pullup_input,
    output logic osc_running,
    output logic stack_clear,
    output logic pc_load,
    output rcw_pkg::prog_addr_t reset_vector,
    output logic nmi_context,
    output logic resume_service,
    output logic resume_next,
    output logic instr_done,
    output rcw_pkg::power_mode_e power_mode
);
    import rcw_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    // Register bits 7..2 hold counter bits 0..5 reversed
    function automatic logic [5:0] flip6(input logic [5:0] v);
        logic [5:0] r;
        r = '0;
        for (int i = 0; i < 6; i++) begin
            r[i] = v[5 - i];
        end
        return r;
    endfunction : flip6

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : hit

    // ****************************************
    // Declarations
    // ****************************************
    logic [3:0] div13_reg, div13_next, div12_reg, div12_next;
    logic ext_meta_reg, ext_sync_reg;
    reset_state_e rst_state_reg, rst_state_next;
    logic [11:0] stab_cnt_reg, stab_cnt_next;
    logic pc_load_reg, pc_load_next;
    logic res_srv_reg, res_srv_next, res_nxt_reg, res_nxt_next;
    logic wd_cause_reg, wd_cause_next;
    power_mode_e mode_reg, mode_next;
    wd_count_t wd_cnt_reg, wd_cnt_next;
    logic wd_c_reg, wd_c_next;
    logic wd_fire_reg, wd_fire_next;
    logic [2:0] mc_left_reg, mc_left_next;
    logic done_reg, done_next;
    logic [7:0] t1_ctrl_reg, t1_ctrl_next, t1_cnt_reg, t1_cnt_next;
    logic [7:0] t1_pre_reg, t1_pre_next, ar_mode_reg, ar_mode_next;
    logic [7:0] popt_reg, popt_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic rst_req, wd_active, commit;
    logic [7:0] wd_view, status_view;

    // ****************************************
    // Clock dividers
    // ****************************************
    // Oscillator halted in stop mode, so both dividers freeze
    always_comb begin
        div13_next = div13_reg;
        div12_next = div12_reg;
        if (mode_reg != pm_stop) begin
            div13_next = (div13_reg == `CORE_DIV - 4'd1) ? 4'd0 : div13_reg + 4'd1;
            div12_next = (div12_reg == `CONV_WD_DIV - 4'd1) ? 4'd0 : div12_reg + 4'd1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            div13_reg <= 4'd0;
            div12_reg <= 4'd0;
        end else begin
            div13_reg <= div13_next;
            div12_reg <= div12_next;
        end
    end

    assign conv_wd_tick = (mode_reg != pm_stop) && (div12_reg == `CONV_WD_DIV - 4'd1);
    assign core_tick = !core_reset && (mode_reg == pm_run)
                       && (div13_reg == `CORE_DIV - 4'd1);

    // ****************************************
    // External reset synchroniser
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
        end else begin
            ext_meta_reg <= ext_reset_n;
            ext_sync_reg <= ext_meta_reg;
        end
    end

    // ****************************************
    // Reset sequencer
    // ****************************************
    assign rst_req = !ext_sync_reg || wd_fire_reg;

    always_comb begin
        rst_state_next = rst_state_reg;
        stab_cnt_next = stab_cnt_reg;
        pc_load_next = 1'b0;
        res_srv_next = 1'b0;
        res_nxt_next = 1'b0;
        wd_cause_next = wd_cause_reg;
        if (!ext_sync_reg) begin
            wd_cause_next = 1'b0;
        end
        // Watchdog firing wins over a pin clear in the same cycle
        if (wd_fire_reg) begin
            wd_cause_next = 1'b1;
        end
        if (rst_req) begin
            // Any pulse, however short, restarts the full delay
            rst_state_next = rs_hold;
            stab_cnt_next = 12'd0;
        end else begin
            unique case (rst_state_reg)
                rs_hold: begin
                    rst_state_next = rs_stab;
                end
                rs_stab: begin
                    stab_cnt_next = stab_cnt_reg + 12'd1;
                    if (stab_cnt_reg == `STAB_CYCLES - 12'd1) begin
                        rst_state_next = rs_init;
                        pc_load_next = 1'b1;
                    end
                end
                rs_init: begin
                    if (return_from_interrupt) begin
                        rst_state_next = rs_normal;
                        res_srv_next = irq_pending;
                        res_nxt_next = !irq_pending;
                    end
                end
                rs_normal: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rst_state_reg <= rs_hold;
            stab_cnt_reg <= 12'd0;
            pc_load_reg <= 1'b0;
            res_srv_reg <= 1'b0;
            res_nxt_reg <= 1'b0;
            wd_cause_reg <= 1'b0;
        end else begin
            rst_state_reg <= rst_state_next;
            stab_cnt_reg <= stab_cnt_next;
            pc_load_reg <= pc_load_next;
            res_srv_reg <= res_srv_next;
            res_nxt_reg <= res_nxt_next;
            wd_cause_reg <= wd_cause_next;
        end
    end

    assign core_reset = (rst_state_reg == rs_hold) || (rst_state_reg == rs_stab);
    assign io_pullup_input = core_reset;
    assign stack_clear = core_reset;
    assign pc_load = pc_load_reg;
    assign reset_vector = `RESET_VECTOR;
    assign nmi_context = rst_state_reg != rs_normal;
    assign resume_service = res_srv_reg;
    assign resume_next = res_nxt_reg;

    // ****************************************
    // Power modes
    // ****************************************
    assign wd_active = watchdog_hw_select || wd_c_reg;

    always_comb begin
        mode_next = mode_reg;
        if (core_reset) begin
            // Reset restarts the oscillator from any mode
            mode_next = pm_run;
        end else begin
            unique case (mode_reg)
                pm_run: begin
                    if (stop_req) begin
                        mode_next = wd_active ? pm_wait : pm_stop;
                    end else if (wait_req) begin
                        mode_next = pm_wait;
                    end
                end
                pm_wait, pm_stop: begin
                    if (wake_irq) begin
                        mode_next = pm_run;
                    end
                end
                default: begin
                    mode_next = pm_run;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mode_reg <= pm_run;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign power_mode = mode_reg;
    assign osc_running = mode_reg != pm_stop;

    // ****************************************
    // Instruction machine cycles
    // ****************************************
    // Unsupported lengths fall back to the shortest instruction
    always_comb begin
        mc_left_next = mc_left_reg;
        done_next = 1'b0;
        if (core_reset) begin
            mc_left_next = 3'd0;
        end else if (mc_left_reg == 3'd0) begin
            if (instr_start) begin
                unique case (instr_cycles)
                    3'd2, 3'd4, 3'd5: mc_left_next = instr_cycles;
                    default: mc_left_next = `INSTR_MIN_CYCLES;
                endcase
            end
        end else if (core_tick) begin
            mc_left_next = mc_left_reg - 3'd1;
            done_next = mc_left_reg == 3'd1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mc_left_reg <= 3'd0;
            done_reg <= 1'b0;
        end else begin
            mc_left_reg <= mc_left_next;
            done_reg <= done_next;
        end
    end

    assign instr_done = done_reg;

    // ****************************************
    // Watchdog
    // ****************************************
    assign commit = write && ack_reg && byteenable[0];

    always_comb begin
        wd_cnt_next = wd_cnt_reg;
        wd_c_next = wd_c_reg;
        wd_fire_next = 1'b0;
        if (core_reset) begin
            wd_cnt_next = 7'h7f;
            wd_c_next = 1'b0;
        end else if (commit && hit(address, `OFS_WD_CTRL)) begin
            wd_cnt_next = {writedata[`WD_SOFT_RESET_BIT], flip6(writedata[7:2])};
            wd_c_next = wd_c_reg | writedata[`WD_ACT_BIT];
            wd_fire_next = !writedata[`WD_SOFT_RESET_BIT];
        end else if (conv_wd_tick) begin
            wd_cnt_next = wd_cnt_reg - 7'd1;
            // Soft-reset bit falling ends the count
            wd_fire_next = wd_active && wd_cnt_reg[6] && !wd_cnt_next[6];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wd_cnt_reg <= 7'h7f;
            wd_c_reg <= 1'b0;
            wd_fire_reg <= 1'b0;
        end else begin
            wd_cnt_reg <= wd_cnt_next;
            wd_c_reg <= wd_c_next;
            wd_fire_reg <= wd_fire_next;
        end
    end

    assign wd_view = {flip6(wd_cnt_reg[5:0]), wd_cnt_reg[6], wd_active};
    assign status_view = {1'b0, wd_cause_reg, mode_reg, osc_running, nmi_context,
                          !wd_active, wd_active};

    // ****************************************
    // Peripheral reset image registers
    // ****************************************
    always_comb begin
        t1_ctrl_next = t1_ctrl_reg;
        t1_cnt_next = t1_cnt_reg;
        t1_pre_next = t1_pre_reg;
        ar_mode_next = ar_mode_reg;
        popt_next = popt_reg;
        if (core_reset) begin
            t1_ctrl_next = `RST_TMR1_CTRL;
            t1_cnt_next = `RST_TMR1_COUNT;
            t1_pre_next = `RST_TMR1_PRESC;
            ar_mode_next = `RST_AR_MODE;
            popt_next = `RST_PORT_OPTION;
        end else if (commit) begin
            if (hit(address, `OFS_TMR1_CTRL)) t1_ctrl_next = writedata[7:0];
            if (hit(address, `OFS_TMR1_COUNT)) t1_cnt_next = writedata[7:0];
            if (hit(address, `OFS_TMR1_PRESC)) t1_pre_next = writedata[7:0];
            if (hit(address, `OFS_AR_MODE)) ar_mode_next = writedata[7:0];
            if (hit(address, `OFS_PORT_OPTION)) popt_next = writedata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            t1_ctrl_reg <= `RST_TMR1_CTRL;
            t1_cnt_reg <= `RST_TMR1_COUNT;
            t1_pre_reg <= `RST_TMR1_PRESC;
            ar_mode_reg <= `RST_AR_MODE;
            popt_reg <= `RST_PORT_OPTION;
        end else begin
            t1_ctrl_reg <= t1_ctrl_next;
            t1_cnt_reg <= t1_cnt_next;
            t1_pre_reg <= t1_pre_next;
            ar_mode_reg <= ar_mode_next;
            popt_reg <= popt_next;
        end
    end

    // ****************************************
    // Avalon-MM slave, one wait state
    // ****************************************
    always_comb begin
        ack_next = (read || write) && !ack_reg;
        rdata_next = rdata_reg;
        if (read && !ack_reg) begin
            rdata_next = 32'h0000_0000;
            unique case (address)
                `OFS_TMR1_CTRL: rdata_next[7:0] = t1_ctrl_reg;
                `OFS_TMR1_COUNT: rdata_next[7:0] = t1_cnt_reg;
                `OFS_TMR1_PRESC: rdata_next[7:0] = t1_pre_reg;
                `OFS_AR_MODE: rdata_next[7:0] = ar_mode_reg;
                `OFS_PORT_OPTION: rdata_next[7:0] = popt_reg;
                `OFS_WD_CTRL: rdata_next[7:0] = wd_view;
                `OFS_CORE_STATUS: rdata_next[7:0] = status_view;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    assign waitrequest = (read || write) && !ack_reg;
    assign readdata = rdata_reg;

endmodule : mcu_reset_clock_watchdog

// ---- tb/mcu_reset_clock_watchdog_sva.sv ----
// Port-level checks of the reset, clock and watchdog block.
// Assumes one domain, sys_clk, with synchronous active-low reset_n.
`timescale 1ns/10ps

module mcu_reset_clock_watchdog_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Pin, option and core
    input wire logic ext_reset_n,
    input wire logic watchdog_hw_select,
    input wire logic return_from_interrupt,
    input wire logic irq_pending,
    // Bus
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic waitrequest,
    // Outputs to the core
    input wire logic core_tick,
    input wire logic conv_wd_tick,
    input wire logic core_reset,
    input wire logic io_pullup_input,
    input wire logic osc_running,
    input wire logic stack_clear,
    input wire logic pc_load,
    input wire rcw_pkg::prog_addr_t reset_vector,
    input wire logic nmi_context,
    input wire logic resume_service,
    input wire logic resume_next,
    input wire rcw_pkg::power_mode_e power_mode
);
    import rcw_pkg::*;
    // ****
    // Helper counters
    // ****
    logic [15:0] high_reg, high_next;
    logic [7:0] gap_reg, gap_next;
    logic seen_reg, seen_next;

    // Gap is only trusted between two ticks of an undisturbed divider
    always_comb begin
        high_next = core_reset ? high_reg + 16'h1 : 16'h0;
        gap_next = conv_wd_tick ? 8'h1 : gap_reg + 8'h1;
        seen_next = conv_wd_tick || seen_reg;
        if (core_reset || power_mode == pm_stop) begin
            gap_next = 8'h1;
            seen_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            high_reg <= 16'h0;
            gap_reg <= 8'h1;
            seen_reg <= 1'b0;
        end else begin
            high_reg <= high_next;
            gap_reg <= gap_next;
            seen_reg <= seen_next;
        end
    end

    // ****
    // Assertions
    // ****
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_pin_holds_reset: assert property (
        (!ext_reset_n) [*8] |-> core_reset && io_pullup_input && osc_running)
        else $error("core not held in reset while pin low");
    a_stab_length: assert property (
        $fell(core_reset) |-> high_reg >= 16'd2048)
        else $error("reset released before the stabilisation count");
    a_init_context: assert property (
        $fell(core_reset) |-> pc_load && nmi_context && !stack_clear
            && reset_vector == 12'hffe)
        else $error("wrong start-up context at reset release");
    a_resume_pick: assert property (
        return_from_interrupt && nmi_context |=> !nmi_context
            && resume_service == $past(irq_pending) && resume_next != $past(irq_pending))
        else $error("wrong resume choice after return");
    a_core_tick_run: assert property (
        core_tick |-> !core_reset && power_mode == pm_run ##1 (!core_tick) [*8])
        else $error("core tick out of run mode or too soon");
    a_wd_tick_gap: assert property (
        conv_wd_tick && seen_reg |-> gap_reg == 8'd12)
        else $error("watchdog tick spacing not twelve");
    a_one_wait: assert property (
        $rose(read || write) |-> waitrequest ##1 !waitrequest)
        else $error("bus answer not after one wait state");
    a_soft_reset: assert property (
        write && !waitrequest && address == 8'hd8 && byteenable[0] && !writedata[1]
            |-> ##[1:4] core_reset)
        else $error("clearing soft reset bit did not reset");
    a_hw_no_stop: assert property (
        watchdog_hw_select |-> power_mode != pm_stop && osc_running)
        else $error("stop mode reached with hardware watchdog");
endmodule : mcu_reset_clock_watchdog_sva

bind mcu_reset_clock_watchdog mcu_reset_clock_watchdog_sva
    mcu_reset_clock_watchdog_sva_inst (.*);

// ---- tb/ext_reset_source.sv ----
// Model of the board device that drives the external reset pin.
// Assumes pulses are requested one at a time by the bench.
`timescale 1ns/10ps

module ext_reset_source (
    // Clock
    input wire logic sys_clk,
    // Pulse request
    input wire logic fire,
    input wire logic [3:0] pulse_len,
    // Pin
    output logic ext_reset_n
);
    logic [3:0] left_reg = 4'h0;
    logic [3:0] left_next;

    // Lengths from one cycle up, so short pulses are exercised too
    always_comb begin
        left_next = left_reg;
        if (fire) begin
            left_next = pulse_len;
        end else if (left_reg != 4'h0) begin
            left_next = left_reg - 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        left_reg <= left_next;
    end

    // Pull-up keeps the pin high between pulses
    assign ext_reset_n = (left_reg == 4'h0);
endmodule : ext_reset_source

// ---- tb/test_mcu_reset_clock_watchdog.sv ----
// Bench for the reset, clock and watchdog block, one task per scenario.
// Assumes the checker binds itself and the pin source model is compiled.
`timescale 1ns/10ps

module test_mcu_reset_clock_watchdog;
    import rcw_pkg::*;
    logic sys_clk = 1'b0, reset_n = 1'b0, watchdog_hw_select = 1'b0, fire = 1'b0;
    logic stop_req = 1'b0, wait_req = 1'b0, wake_irq = 1'b0, irq_pending = 1'b0;
    logic return_from_interrupt = 1'b0, instr_start = 1'b0, read = 1'b0, write = 1'b0;
    logic [2:0] instr_cycles = 3'h2;
    logic [3:0] pulse_len = 4'h1, byteenable = 4'h1;
    logic [7:0] address = 8'h00, q;
    logic [31:0] writedata = 32'h0, readdata;
    logic ext_reset_n, waitrequest, core_tick, conv_wd_tick, core_reset, io_pullup_input;
    logic osc_running, stack_clear, pc_load, nmi_context, resume_service, resume_next;
    logic instr_done;
    prog_addr_t reset_vector;
    power_mode_e power_mode;
    int errors = 0, compares = 0, n;

    mcu_reset_clock_watchdog mcu_reset_clock_watchdog_inst (.*);
    ext_reset_source ext_reset_source_inst (.*);

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    // ****
    // Shared tasks
    // ****
    task automatic give_verdict;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int k;
        logic w;
        k = 0;
        @(posedge sys_clk);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= !wr;
        // Answer and read data are taken at the edge that ends the request
        do begin
            @(posedge sys_clk);
            w = waitrequest;
            q = readdata[7:0];
            k++;
        end while (w !== 1'b0 && k < 20);
        read <= 1'b0;
        write <= 1'b0;
        if (k >= 20) begin
            chk(12'h0, 12'h1);
            give_verdict;
        end
    endtask : bus

    task automatic wait_rst(input logic want, input int lim, output int k);
        k = 0;
        while (core_reset !== want && k < lim) begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= lim) begin
            chk(12'h0, 12'h1);
            give_verdict;
        end
    endtask : wait_rst

    task automatic strobe(input int s);
        @(posedge sys_clk);
        stop_req <= (s == 0);
        wait_req <= (s == 1);
        wake_irq <= (s == 2);
        @(posedge sys_clk);
        {stop_req, wait_req, wake_irq} <= 3'h0;
        @(negedge sys_clk);
    endtask : strobe

    task automatic t_pin(input logic [3:0] len);
        @(posedge sys_clk);
        fire <= 1'b1;
        pulse_len <= len;
        @(posedge sys_clk);
        fire <= 1'b0;
    endtask : t_pin

    task automatic t_gap(input logic wd);
        int k;
        k = 0;
        while ((wd ? conv_wd_tick : core_tick) !== 1'b1 && k < 30) begin
            @(negedge sys_clk);
            k++;
        end
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while ((wd ? conv_wd_tick : core_tick) !== 1'b1 && k < 30);
        chk(12'(k), wd ? 12'd12 : 12'd13);
    endtask : t_gap

    // ****
    // Scenarios
    // ****
    task automatic t_boot(input logic pend);
        int k;
        wait_rst(1'b1, 900, k);
        wait_rst(1'b0, 2100, k);
        chk(12'(k inside {[2048:2070]}), 12'h1);
        chk({9'h0, pc_load, nmi_context, io_pullup_input}, 12'h6);
        chk(reset_vector, 12'hffe);
        @(posedge sys_clk);
        return_from_interrupt <= 1'b1;
        irq_pending <= pend;
        @(posedge sys_clk);
        return_from_interrupt <= 1'b0;
        @(negedge sys_clk);
        chk({9'h0, resume_service, resume_next, nmi_context}, {9'h0, pend, !pend, 1'b0});
    endtask : t_boot

    task automatic t_regs;
        logic [7:0] adr [6] = '{8'hc0, 8'hc4, 8'hc8, 8'hcc, 8'hd0, 8'he0};
        logic [7:0] rst [6] = '{8'h00, 8'hff, 8'h7f, 8'h00, 8'h00, 8'h00};
        bus(1'b0, 8'hd8, 8'h0);
        chk({5'h0, q[6:0]}, 12'h07e);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, adr[i], 8'h0);
            chk({4'h0, q}, {4'h0, rst[i]});
        end
        bus(1'b1, 8'he0, 8'h55);
        bus(1'b0, 8'he0, 8'h0);
        chk({4'h0, q}, 12'h000);
    endtask : t_regs

    task automatic t_instr;
        int d [4];
        logic [2:0] c [4] = '{3'd2, 3'd4, 3'd5, 3'd7};
        for (int i = 0; i < 4; i++) begin
            t_gap(1'b0);
            @(posedge sys_clk);
            instr_start <= 1'b1;
            instr_cycles <= c[i];
            @(posedge sys_clk);
            instr_start <= 1'b0;
            d[i] = 0;
            while (instr_done !== 1'b1 && d[i] < 100) begin
                @(negedge sys_clk);
                d[i]++;
            end
        end
        chk(12'(d[1] - d[0]), 12'd26);
        chk(12'(d[2] - d[1]), 12'd13);
        chk(12'(d[3]), 12'(d[0]));
    endtask : t_instr

    task automatic t_pinrst;
        bus(1'b1, 8'hc8, 8'h11);
        t_pin(4'h1);
        t_boot(1'b0);
        bus(1'b0, 8'hc8, 8'h0);
        chk({4'h0, q}, 12'h07f);
        bus(1'b1, 8'hd8, 8'hfc);
        wait_rst(1'b1, 6, n);
        t_boot(1'b0);
    endtask : t_pinrst

    task automatic t_wd;
        bus(1'b1, 8'hd8, 8'h43);
        wait_rst(1'b1, 60, n);
        chk(12'(n inside {[24:45]}), 12'h1);
        t_boot(1'b0);
        bus(1'b0, 8'hdc, 8'h0);
        chk({11'h0, q[6]}, 12'h1);
        bus(1'b0, 8'hd8, 8'h0);
        chk({10'h0, q[1:0]}, 12'h2);
        bus(1'b1, 8'hd8, 8'hff);
        for (int i = 0; i < 4; i++) begin
            repeat (400) @(posedge sys_clk);
            chk({11'h0, core_reset}, 12'h0);
            bus(1'b1, 8'hd8, i == 3 ? 8'hfe : 8'hff);
        end
        bus(1'b0, 8'hd8, 8'h0);
        chk({11'h0, q[0]}, 12'h1);
        wait_rst(1'b1, 900, n);
        t_boot(1'b0);
    endtask : t_wd

    task automatic t_stop;
        strobe(0);
        chk({9'h0, osc_running, power_mode}, {9'h0, 1'b0, pm_stop});
        strobe(2);
        chk({10'h0, power_mode}, {10'h0, pm_run});
        t_gap(1'b1);
        strobe(1);
        chk({9'h0, osc_running, power_mode}, {9'h0, 1'b1, pm_wait});
        strobe(2);
        strobe(0);
        t_pin(4'hf);
        wait_rst(1'b1, 10, n);
        repeat (3) @(negedge sys_clk);
        chk({10'h0, osc_running, io_pullup_input}, 12'h3);
        t_boot(1'b0);
    endtask : t_stop

    task automatic t_hw;
        @(posedge sys_clk);
        watchdog_hw_select <= 1'b1;
        t_pin(4'h2);
        t_boot(1'b0);
        bus(1'b0, 8'hd8, 8'h0);
        chk({10'h0, q[1:0]}, 12'h3);
        bus(1'b1, 8'hd8, 8'hfe);
        bus(1'b0, 8'hd8, 8'h0);
        chk({11'h0, q[0]}, 12'h1);
        strobe(0);
        chk({9'h0, osc_running, power_mode}, {9'h0, 1'b1, pm_wait});
        strobe(2);
        wait_rst(1'b1, 900, n);
    endtask : t_hw

    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_boot(1'b1);
        t_regs;
        t_gap(1'b1);
        t_instr;
        t_pinrst;
        t_wd;
        t_stop;
        t_hw;
        give_verdict;
    end
endmodule : test_mcu_reset_clock_watchdog
